/* shared/arc_pkg.sv */
// Package with register map, field layout and reset values of the result comparator.
`default_nettype none

package arc_pkg;

    // ------------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFFSET     = 8'h18;  // Comparator control register.
    localparam logic [7:0]  IRQ_STAT_OFFSET = 8'h40;  // Sticky event status.
    localparam logic [7:0]  IRQ_MASK_OFFSET = 8'h44;  // Event mask.
    localparam logic [7:0]  MATCH_CNT_OFFSET = 8'h48; // Internal match counter, read only.

    // ------------------------------------------------------------------
    // Field positions of the control register.
    // ------------------------------------------------------------------
    localparam int EN_BIT    = 0;   // Compare enable.
    localparam int IE_BIT    = 1;   // Match interrupt enable.
    localparam int COND_BIT  = 2;   // Condition select.
    localparam int FLAG_BIT  = 7;   // Match flag.
    localparam int TGT_LSB   = 8;   // Match count target, low bit.
    localparam int TGT_MSB   = 11;  // Match count target, high bit.
    localparam int THR_LSB   = 16;  // Threshold, low bit.
    localparam int THR_MSB   = 31;  // Threshold, high bit.

    // ------------------------------------------------------------------
    // Widths and reset values.
    // ------------------------------------------------------------------
    localparam int          ADDR_W    = 8;
    localparam int          DATA_W    = 32;
    localparam int          RES_W     = 16;
    localparam int          CNT_W     = 5;       // Holds target plus one up to 16.
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [1:0]  EVT_RST   = 2'h0;    // Bit 0 match, bit 1 lost result.
    localparam logic [4:0]  CNT_ZERO  = 5'h00;
    localparam logic [4:0]  CNT_ONE   = 5'h01;

    // Comparator state.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_ARMED = 2'b10
    } arc_state_t;

endpackage : arc_pkg

`default_nettype wire

/* core/arc_match_test.sv */
// Combinational match test of one converter result against the threshold.
`default_nettype none

module arc_match_test (
    // Operands.
    input  wire logic [15:0] result,      // Result leaving the FIFO.
    input  wire logic [15:0] threshold,   // Programmed threshold.
    input  wire logic        cond_ge,     // 1 selects greater-or-equal.
    // Outcome.
    output logic             hit          // Result meets the selected condition.
);

    // --------------------------------------------------------------------
    // Condition select.
    // --------------------------------------------------------------------
    // Unsigned compare; the converter delivers unsigned codes.
    always_comb begin
        if (cond_ge) begin
            hit = (result >= threshold);
        end else begin
            hit = (result < threshold);
        end
    end

endmodule : arc_match_test

`default_nettype wire

/* core/arc_result_comparator.sv */
// Result comparator: threshold test, match counting, flag, interrupt and register port.
//
// The address-and-strobe port was left to the implementer.
`default_nettype none

module arc_result_comparator (
    // Clock and reset.
    input  wire logic        clk,          // 40 MHz peripheral clock.
    input  wire logic        rst_b,        // Asynchronous active-low reset.
    // Converter result FIFO output.
    input  wire logic        res_valid,    // A result leaves the FIFO this cycle.
    input  wire logic [15:0] res_data,     // Result value.
    // Register port.
    input  wire logic [7:0]  reg_addr,     // Byte address.
    input  wire logic [31:0] reg_wdata,    // Write data.
    input  wire logic        reg_wr,       // Write strobe.
    input  wire logic        reg_rd,       // Read strobe.
    output logic      [31:0] reg_rdata,    // Read data, cycle after the strobe.
    // Interrupts.
    output logic             match_irq,    // Compare interrupt request, level.
    output logic             evt_irq       // Masked status interrupt, level.
);

    // --------------------------------------------------------------------
    // Reset release.
    // --------------------------------------------------------------------
    logic rst_s1_q;  // First stage, read only by the second.
    logic rst_s2_q;  // Released reset for the rest of the design.

    // Assert asynchronously, release through two flip-flops.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    wire logic rst_n = rst_s2_q;  // Internal active-low reset.

    // --------------------------------------------------------------------
    // Register state.
    // --------------------------------------------------------------------
    logic [15:0]            thr_q,  thr_d;   // Threshold value.
    logic [3:0]             tgt_q,  tgt_d;   // Match count target.
    logic                   flag_q, flag_d;  // Match flag.
    logic                   cond_q, cond_d;  // Condition select.
    logic                   ie_q,   ie_d;    // Match interrupt enable.
    logic                   en_q,   en_d;    // Compare enable.
    logic [4:0]             cnt_q,  cnt_d;   // Internal match counter.
    logic [1:0]             stat_q, stat_d;  // Sticky event status.
    logic [1:0]             mask_q, mask_d;  // Event mask.
    logic [31:0]            rd_q,   rd_d;    // Read data register.
    logic                   mirq_q, mirq_d;  // Match interrupt output.
    logic                   eirq_q, eirq_d;  // Event interrupt output.
    arc_pkg::arc_state_t    st_q,   st_d;    // Comparator state.

    logic hit;  // Current result meets the condition.

    // Threshold test lives in its own leaf.
    arc_match_test u_test (
        .result    (res_data),
        .threshold (thr_q),
        .cond_ge   (cond_q),
        .hit       (hit)
    );

    // Decodes a register address.
    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
        return (a == off);
    endfunction : is_addr

    wire logic wr_ctrl = reg_wr && is_addr(reg_addr, arc_pkg::CTRL_OFFSET);
    wire logic flag_clr = wr_ctrl && reg_wdata[arc_pkg::FLAG_BIT];
    wire logic compare  = (st_q == arc_pkg::ST_ARMED) && res_valid && en_q;
    wire logic match    = compare && hit;
    // The flag sets when the count would reach target plus one.
    wire logic reach    = match && ((cnt_q + arc_pkg::CNT_ONE) == ({1'b0, tgt_q} + arc_pkg::CNT_ONE));
    // A match while the flag is already set, with no flag clear written in the same cycle, is counted as lost.
    wire logic lost     = match && flag_q && !flag_clr;

    // --------------------------------------------------------------------
    // Next-state logic.
    // --------------------------------------------------------------------
    // Flag set wins over a clear in the same cycle, so no event is lost.
    always_comb begin
        thr_d  = thr_q;
        tgt_d  = tgt_q;
        cond_d = cond_q;
        ie_d   = ie_q;
        en_d   = en_q;
        mask_d = mask_q;
        st_d   = st_q;
        cnt_d  = cnt_q;
        flag_d = flag_q;
        stat_d = stat_q;
        rd_d   = 32'h0000_0000;
        // Software writes.
        if (wr_ctrl) begin
            thr_d  = reg_wdata[arc_pkg::THR_MSB:arc_pkg::THR_LSB];
            tgt_d  = reg_wdata[arc_pkg::TGT_MSB:arc_pkg::TGT_LSB];
            cond_d = reg_wdata[arc_pkg::COND_BIT];
            ie_d   = reg_wdata[arc_pkg::IE_BIT];
            en_d   = reg_wdata[arc_pkg::EN_BIT];
        end
        if (reg_wr && is_addr(reg_addr, arc_pkg::IRQ_MASK_OFFSET)) begin
            mask_d = reg_wdata[1:0];
        end
        if (reg_wr && is_addr(reg_addr, arc_pkg::IRQ_STAT_OFFSET)) begin
            stat_d = stat_q & ~reg_wdata[1:0];  // Write one to clear.
        end
        // State follows the enable bit.
        case (st_q)
            arc_pkg::ST_IDLE:  if (en_q) begin
                st_d = arc_pkg::ST_ARMED;
            end
            arc_pkg::ST_ARMED: if (!en_q) begin
                st_d = arc_pkg::ST_IDLE;
            end
            default:           st_d = arc_pkg::ST_IDLE;
        endcase
        // Counting.
        if (!en_q || flag_clr) begin
            cnt_d = arc_pkg::CNT_ZERO;
        end
        if (match) begin
            if (reach) begin
                cnt_d = arc_pkg::CNT_ZERO;  // Restart after a hit of the target.
            end else if (!flag_clr) begin
                cnt_d = cnt_q + arc_pkg::CNT_ONE;
            end else begin
                cnt_d = arc_pkg::CNT_ONE;
            end
        end
        // Flag.
        if (flag_clr) begin
            flag_d = 1'b0;
        end
        if (reach) begin
            flag_d = 1'b1;
        end
        // Sticky events: set wins over clear.
        if (reach) begin
            stat_d[0] = 1'b1;
        end
        if (lost) begin
            stat_d[1] = 1'b1;
        end
        // Read data.
        if (reg_rd) begin
            if (is_addr(reg_addr, arc_pkg::CTRL_OFFSET)) begin
                rd_d = {thr_q, 4'h0, tgt_q, flag_q, 4'h0, cond_q, ie_q, en_q};
            end else if (is_addr(reg_addr, arc_pkg::IRQ_STAT_OFFSET)) begin
                rd_d = {30'h0000_0000, stat_q};
            end else if (is_addr(reg_addr, arc_pkg::IRQ_MASK_OFFSET)) begin
                rd_d = {30'h0000_0000, mask_q};
            end else if (is_addr(reg_addr, arc_pkg::MATCH_CNT_OFFSET)) begin
                rd_d = {27'h000_0000, cnt_q};
            end
        end
        mirq_d = flag_d && ie_d;
        eirq_d = |(stat_d & mask_d);
    end

    // --------------------------------------------------------------------
    // State registers.
    // --------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thr_q  <= arc_pkg::CTRL_RST[arc_pkg::THR_MSB:arc_pkg::THR_LSB];
            tgt_q  <= arc_pkg::CTRL_RST[arc_pkg::TGT_MSB:arc_pkg::TGT_LSB];
            flag_q <= arc_pkg::CTRL_RST[arc_pkg::FLAG_BIT];
            cond_q <= arc_pkg::CTRL_RST[arc_pkg::COND_BIT];
            ie_q   <= arc_pkg::CTRL_RST[arc_pkg::IE_BIT];
            en_q   <= arc_pkg::CTRL_RST[arc_pkg::EN_BIT];
            cnt_q  <= arc_pkg::CNT_ZERO;
            stat_q <= arc_pkg::EVT_RST;
            mask_q <= arc_pkg::EVT_RST;
            rd_q   <= 32'h0000_0000;
            mirq_q <= 1'b0;
            eirq_q <= 1'b0;
            st_q   <= arc_pkg::ST_IDLE;
        end else begin
            thr_q  <= thr_d;
            tgt_q  <= tgt_d;
            flag_q <= flag_d;
            cond_q <= cond_d;
            ie_q   <= ie_d;
            en_q   <= en_d;
            cnt_q  <= cnt_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rd_q   <= rd_d;
            mirq_q <= mirq_d;
            eirq_q <= eirq_d;
            st_q   <= st_d;
        end
    end

    assign reg_rdata = rd_q;
    assign match_irq = mirq_q;
    assign evt_irq   = eirq_q;

    // --------------------------------------------------------------------
    // Assertions.
    // --------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_no_count_disabled: assert property (!en_q |=> cnt_q == arc_pkg::CNT_ZERO)
        else $error("Counter moved while compare disabled.");
    a_cond_select: assert property (compare |-> hit == (cond_q ? res_data >= thr_q : res_data < thr_q))
        else $error("Match test does not follow condition select.");
    a_count_step: assert property (match && !reach && !flag_clr && en_q |=>
        cnt_q == $past(cnt_q) + arc_pkg::CNT_ONE)
        else $error("Counter did not step by one on a match.");
    a_flag_reach: assert property (match && cnt_q == {1'b0, tgt_q} |=> flag_q)
        else $error("Flag not set at target plus one matches.");
    a_flag_clear: assert property (flag_clr && !reach |=> !flag_q)
        else $error("Flag not cleared by writing one.");
    a_flag_keep: assert property (flag_q && !flag_clr |=> flag_q)
        else $error("Flag dropped without a clear.");
    a_irq_follow: assert property (match_irq == (flag_q && ie_q))
        else $error("Interrupt request disagrees with flag and enable.");
    a_cnt_restart: assert property (flag_clr && !match |=> cnt_q == arc_pkg::CNT_ZERO)
        else $error("Counter not zeroed on flag clear.");
    a_read_latency: assert property (reg_rd && is_addr(reg_addr, arc_pkg::MATCH_CNT_OFFSET) |=>
        reg_rdata[4:0] == $past(cnt_q))
        else $error("Read data not one cycle later.");

    c_flag_set:  cover property (!flag_q ##1 flag_q);
    c_irq_raise: cover property (!match_irq ##1 match_irq);
    c_set_clear: cover property (flag_clr && reach);
    c_lost:      cover property (lost);

endmodule : arc_result_comparator

`default_nettype wire

/* sim/arc_fifo_model.sv */
// Behavioural model of the converter result FIFO output that feeds the comparator.
`default_nettype none

module arc_fifo_model (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Bench request.
    input  wire logic        push,        // Pop one result in the next cycle.
    input  wire logic [15:0] push_data,   // Result to hand over.
    // FIFO output.
    output logic             res_valid,   // One cycle per result.
    output logic      [15:0] res_data     // Result value.
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // Output register.
    // ------------------------------------------------------------------
    // Between pops the data lines flip every cycle, so a design that samples
    // them without res_valid sees changing garbage instead of a stale hit.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            res_valid <= 1'b0;
            res_data  <= 16'hA5A5;
        end else if (push) begin
            res_valid <= 1'b1;
            res_data  <= push_data;
        end else begin
            res_valid <= 1'b0;
            res_data  <= ~res_data;
        end
    end
endmodule : arc_fifo_model

`default_nettype wire

/* sim/arc_result_comparator_tb_top.sv */
// Self-checking testbench of the result comparator.
`default_nettype none

module arc_result_comparator_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // Signals and counters.
    // ------------------------------------------------------------------
    logic        clk;          // 40 MHz clock.
    logic        rst_b;        // Active-low reset.
    logic        push;         // Request to the FIFO model.
    logic [15:0] push_data;    // Result for the FIFO model.
    logic        res_valid;    // FIFO output strobe.
    logic [15:0] res_data;     // FIFO output data.
    logic [7:0]  reg_addr;     // Register address.
    logic [31:0] reg_wdata;    // Register write data.
    logic        reg_wr;       // Write strobe.
    logic        reg_rd;       // Read strobe.
    logic [31:0] reg_rdata;    // Read data.
    logic        match_irq;    // Compare interrupt.
    logic        evt_irq;      // Status interrupt.
    logic [31:0] rd_val;       // Last value read.
    logic [31:0] c;            // Control word of the running scenario.
    int          err_count;    // Mismatches seen.
    int          tests_run;    // Comparisons made.

    arc_fifo_model fifo (.clk(clk), .rst_b(rst_b), .push(push), .push_data(push_data),
                         .res_valid(res_valid), .res_data(res_data));

    arc_result_comparator uut (.clk(clk), .rst_b(rst_b), .res_valid(res_valid), .res_data(res_data),
                               .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
                               .reg_rdata(reg_rdata), .match_irq(match_irq), .evt_irq(evt_irq));

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    // Control word from its fields; reserved bits stay zero.
    function automatic logic [31:0] ctl(logic [15:0] thr, logic [3:0] tgt, logic cond, logic ie, logic en, logic fl);
        return {thr, 4'h0, tgt, fl, 4'h0, cond, ie, en};
    endfunction : ctl

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample just then.
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        rd_val = reg_rdata;
        chk(rd_val, exp);
    endtask : rchk

    // One result through the FIFO, then room for the flag to land.
    task automatic send(input logic [15:0] v);
        @(posedge clk);
        push      <= 1'b1;
        push_data <= v;
        @(posedge clk);
        push      <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : send

    task automatic irqchk(input logic m, input logic e);
        @(posedge clk);
        #1;
        chk({30'h0, match_irq, evt_irq}, {30'h0, m, e});
    endtask : irqchk

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_reset();
        rchk(arc_pkg::CTRL_OFFSET, 32'h0000_0000);
        rchk(arc_pkg::MATCH_CNT_OFFSET, 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFFF);
        rchk(8'h20, 32'h0000_0000);
        irqchk(1'b0, 1'b0);
    endtask : t_reset

    task automatic t_disabled();
        c = ctl(16'h0100, 4'h0, 1'b1, 1'b1, 1'b0, 1'b0);
        wr(arc_pkg::CTRL_OFFSET, c);
        send(16'h0200);
        rchk(arc_pkg::CTRL_OFFSET, c);
        rchk(arc_pkg::MATCH_CNT_OFFSET, 32'h0000_0000);
        irqchk(1'b0, 1'b0);
    endtask : t_disabled

    task automatic t_ge();
        c = ctl(16'h0100, 4'h0, 1'b1, 1'b0, 1'b1, 1'b0);
        wr(arc_pkg::CTRL_OFFSET, c);
        send(16'h00FF);
        rchk(arc_pkg::CTRL_OFFSET, c);
        send(16'h0100);
        rchk(arc_pkg::CTRL_OFFSET, c | 32'h0000_0080);
        irqchk(1'b0, 1'b0);
        rchk(arc_pkg::IRQ_STAT_OFFSET, 32'h0000_0001);
        // A second hit while the flag stands sets the lost-result event as well.
        send(16'h0200);
        rchk(arc_pkg::IRQ_STAT_OFFSET, 32'h0000_0003);
        wr(arc_pkg::IRQ_MASK_OFFSET, 32'h0000_0001);
        irqchk(1'b0, 1'b1);
        wr(arc_pkg::IRQ_STAT_OFFSET, 32'h0000_0001);
        wr(arc_pkg::IRQ_MASK_OFFSET, 32'h0000_0000);
        irqchk(1'b0, 1'b0);
        // Writing zero to the flag bit while enabling the interrupt keeps the flag.
        c = ctl(16'h0100, 4'h0, 1'b1, 1'b1, 1'b1, 1'b0);
        wr(arc_pkg::CTRL_OFFSET, c);
        irqchk(1'b1, 1'b0);
        wr(arc_pkg::CTRL_OFFSET, c | 32'h0000_0080);
        irqchk(1'b0, 1'b0);
        rchk(arc_pkg::CTRL_OFFSET, c);
    endtask : t_ge

    task automatic t_lt();
        c = ctl(16'h0100, 4'h2, 1'b0, 1'b0, 1'b1, 1'b0);
        wr(arc_pkg::CTRL_OFFSET, c);
        send(16'h00FF);
        send(16'h0001);
        rchk(arc_pkg::MATCH_CNT_OFFSET, 32'h0000_0002);
        send(16'h0100);
        rchk(arc_pkg::MATCH_CNT_OFFSET, 32'h0000_0002);
        rchk(arc_pkg::CTRL_OFFSET, c);
        send(16'h0000);
        rchk(arc_pkg::CTRL_OFFSET, c | 32'h0000_0080);
        wr(arc_pkg::CTRL_OFFSET, c | 32'h0000_0080);
        rchk(arc_pkg::CTRL_OFFSET, c);
        send(16'h0005);
        rchk(arc_pkg::MATCH_CNT_OFFSET, 32'h0000_0001);
        wr(arc_pkg::CTRL_OFFSET, c & 32'hFFFF_FFFE);
        rchk(arc_pkg::MATCH_CNT_OFFSET, 32'h0000_0000);
    endtask : t_lt

    // ------------------------------------------------------------------
    // Verdict.
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // Clock, sequence and watchdog.
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        {rst_b, push, push_data, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        err_count = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        // The design releases reset through two flops internally.
        repeat (3) @(posedge clk);
        t_reset();
        t_disabled();
        t_ge();
        t_lt();
        summarize();
    end

    // The scenarios need about 115 cycles; 4000 leaves ample margin.
    initial begin
        #100000;
        err_count++;
        summarize();
    end
endmodule : arc_result_comparator_tb_top

`default_nettype wire
